// ===== pkg/ddr_mode_pkg.sv
// Purpose: constants for mode decode and burst order
// Assumes: command pins sampled on i_clk
// Notes:   field positions follow the address bus
package ddr_mode_pkg;
  localparam int ADDR_W = 13;
  // base mode fields
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int LOOP_RST_BIT = 8;
  localparam int HI_LSB = 7;
  // extended mode fields
  localparam int DLL_DIS_BIT = 0;
  localparam int DRV_BIT = 1;
  localparam logic [12:0] MODE_RST = 13'h0000;
  // burst length codes
  localparam logic [2:0] BL_CODE2 = 3'h1;
  localparam logic [2:0] BL_CODE4 = 3'h2;
  localparam logic [2:0] BL_CODE8 = 3'h3;
  // latency codes
  localparam logic [2:0] CL_CODE2 = 3'h2;
  localparam logic [2:0] CL_CODE3 = 3'h3;
  localparam logic [2:0] CL_CODE25 = 3'h6;
  // high field values
  localparam logic [5:0] HI_NORMAL = 6'h00;
  localparam logic [5:0] HI_LOOP_RST = 6'h02;
  // command codes {cs_n,ras_n,cas_n,we_n}
  localparam logic [3:0] CMD_MODE_SET = 4'h0;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam int FIFO_DEPTH = 32;
endpackage

// ===== core/ddr_mode_and_burst_order.sv
// How it works
// - bursts of 2, 4, 8 both orders
// - length two: A0 start, A1 up block
// - length four: A1:A0 start, A2 up block
// - length eight: A2:A0 start, upper bits block
// - burst wraps inside its block
// - one length for reads and writes
// - burst type bit picks order
// - sequential is start plus i modulo length
// - interleaved is start xor i
// - latency three: data two clocks later
// - latency two: data one clock later
// - high bits zero select normal mode
// - loop reset bit alone resets loop
// - bank bits 01 write extended register
// - self refresh exit enables the loop; an extended write in the same cycle wins
// - extended option selects reduced drive
// - length, type, latency, loop reset field positions
// - bank bits 00 write base register
//
// Purpose: mode registers and burst column sequencing
// Assumes: commands on i_clk, i_ce gates all state
// Notes:   column stream buffered in a FIFO
`timescale 1ns/1ps

// column FIFO with registered head
module col_fifo #(
  parameter int W     = 14,
  parameter int DEPTH = 32
) (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_valid,
  output logic              o_ready,
  output logic [W-1:0]      o_data,
  output logic              o_valid,
  input  wire logic         i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;
  logic          load;
  // head register refills when empty or drained
  assign push = i_valid && o_ready;
  assign load = (cnt_reg != '0) && (!o_valid || i_ready);
  assign pop  = load;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
      o_valid <= 1'b0;
      o_data  <= '0;
      o_ready <= 1'b0;
    end else if (i_ce) begin
      if (push) begin
        mem[wr_reg] <= i_data;
        wr_reg      <= wr_reg + AW'(1);
      end
      if (pop) begin
        o_data <= mem[rd_reg];
        rd_reg <= rd_reg + AW'(1);
      end
      if (load)
        o_valid <= 1'b1;
      else if (i_ready)
        o_valid <= 1'b0;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      o_ready <= (cnt_reg + (AW+1)'(push) - (AW+1)'(pop)) < (AW+1)'(DEPTH - 1);
    end
  end
endmodule

module ddr_mode_and_burst_order #(
  parameter int COL_W = 13,
  parameter int DEPTH = ddr_mode_pkg::FIFO_DEPTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_ce,
  input  wire logic             i_cs_n,
  input  wire logic             i_ras_n,
  input  wire logic             i_cas_n,
  input  wire logic             i_we_n,
  input  wire logic             i_bank_select_bit0,
  input  wire logic             i_bank_select_bit1,
  input  wire logic [12:0]      i_addr,
  input  wire logic             i_self_refresh_exit,
  input  wire logic             i_col_ready,
  output logic [COL_W-1:0]      o_col,
  output logic                  o_col_write,
  output logic                  o_col_valid,
  output logic                  o_cmd_ready,
  output logic                  o_first_data,
  output logic                  o_first_data_half,
  output logic [3:0]            o_burst_len,
  output logic                  o_interleaved,
  output logic                  o_loop_enable,
  output logic                  o_loop_reset,
  output logic                  o_reduced_drive,
  output logic                  o_reserved_mode,
  output logic                  o_reserved_code
);
  // burst sequencer states
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_BURST = 1'b1
  } burst_state_t;

  // low-bit mask for a decoded length
  function automatic logic [2:0] len_mask(input logic [2:0] code);
    case (code)
      ddr_mode_pkg::BL_CODE2: len_mask = 3'h1;
      ddr_mode_pkg::BL_CODE4: len_mask = 3'h3;
      ddr_mode_pkg::BL_CODE8: len_mask = 3'h7;
      default:                len_mask = 3'h0;
    endcase
  endfunction

  // i-th column inside the block
  function automatic logic [COL_W-1:0] burst_col(
    input logic [COL_W-1:0] start,
    input logic [2:0]       idx,
    input logic [2:0]       mask,
    input logic             ilv
  );
    logic [2:0] lo;
    lo = ilv ? (start[2:0] ^ idx) : (start[2:0] + idx);
    burst_col = (start & ~COL_W'(mask)) | COL_W'(lo & mask);
  endfunction

  logic [12:0]      base_mode_reg;
  logic [12:0]      extended_mode_reg;
  burst_state_t     state_reg;
  burst_state_t     state_next;
  logic [COL_W-1:0] start_reg;
  logic [2:0]       idx_reg;
  logic [2:0]       mask_reg;
  logic             ilv_reg;
  logic             wr_reg;
  logic             lat_reg;
  logic [3:0]       cmd;
  logic             mode_set;
  logic             is_read;
  logic             is_write;
  logic             take;
  logic             fifo_ready;
  logic             fifo_push;
  logic [2:0]       bl_code;
  logic [2:0]       cl_code;
  logic [5:0]       hi_bits;
  logic [2:0]       cur_mask;
  logic             bl_ok;
  logic             cl_ok;
  logic [COL_W-1:0] col_now;

  // command decode
  assign cmd      = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
  assign mode_set = (cmd == ddr_mode_pkg::CMD_MODE_SET);
  assign is_read  = (cmd == ddr_mode_pkg::CMD_READ);
  assign is_write = (cmd == ddr_mode_pkg::CMD_WRITE);

  // mode field decode
  assign bl_code  = base_mode_reg[ddr_mode_pkg::BL_LSB +: 3];
  assign cl_code  = base_mode_reg[ddr_mode_pkg::CL_LSB +: 3];
  assign hi_bits  = base_mode_reg[ddr_mode_pkg::HI_LSB +: 6];
  assign cur_mask = len_mask(bl_code);
  assign bl_ok    = (cur_mask != 3'h0);
  assign cl_ok    = (cl_code == ddr_mode_pkg::CL_CODE2) ||
                    (cl_code == ddr_mode_pkg::CL_CODE3) ||
                    (cl_code == ddr_mode_pkg::CL_CODE25);

  // burst launch and column stream
  assign take       = (is_read || is_write) && bl_ok && fifo_ready;
  assign col_now    = burst_col(start_reg, idx_reg, mask_reg, ilv_reg);
  assign fifo_push  = (state_reg == ST_BURST) && fifo_ready;
  assign o_cmd_ready = fifo_ready;

  // next burst state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take)
          state_next = ST_BURST;
      end
      ST_BURST: begin
        if (fifo_push && idx_reg == mask_reg && !take)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // mode registers, stored on mode set command
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      base_mode_reg     <= ddr_mode_pkg::MODE_RST;
      extended_mode_reg <= ddr_mode_pkg::MODE_RST;
    end else if (i_ce) begin
      if (mode_set && !i_bank_select_bit1 && !i_bank_select_bit0)
        base_mode_reg <= i_addr;
      if (mode_set && !i_bank_select_bit1 && i_bank_select_bit0)
        extended_mode_reg <= i_addr;
      else if (i_self_refresh_exit)
        extended_mode_reg[ddr_mode_pkg::DLL_DIS_BIT] <= 1'b0;
    end
  end

  // burst sequencer; a new command truncates the old burst
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= ST_IDLE;
      start_reg <= '0;
      idx_reg   <= 3'h0;
      mask_reg  <= 3'h0;
      ilv_reg   <= 1'b0;
      wr_reg    <= 1'b0;
    end else if (i_ce) begin
      state_reg <= state_next;
      if (take) begin
        start_reg <= i_addr[COL_W-1:0];
        idx_reg   <= 3'h0;
        mask_reg  <= cur_mask;
        ilv_reg   <= base_mode_reg[ddr_mode_pkg::BT_BIT];
        wr_reg    <= is_write;
      end else if (fifo_push) begin
        idx_reg <= idx_reg + 3'h1;
      end
    end
  end

  // read latency timing
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lat_reg           <= 1'b0;
      o_first_data      <= 1'b0;
      o_first_data_half <= 1'b0;
    end else if (i_ce) begin
      lat_reg <= is_read && take;
      if (cl_code == ddr_mode_pkg::CL_CODE3)
        o_first_data <= lat_reg;
      else
        o_first_data <= is_read && take && cl_ok;
      o_first_data_half <= (cl_code == ddr_mode_pkg::CL_CODE25);
    end
  end

  // mode status outputs
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_burst_len     <= 4'h0;
      o_interleaved   <= 1'b0;
      o_loop_enable   <= 1'b0;
      o_loop_reset    <= 1'b0;
      o_reduced_drive <= 1'b0;
      o_reserved_mode <= 1'b0;
      o_reserved_code <= 1'b0;
    end else if (i_ce) begin
      o_burst_len     <= {1'b0, cur_mask} + 4'h1;
      o_interleaved   <= base_mode_reg[ddr_mode_pkg::BT_BIT];
      o_loop_enable   <= !extended_mode_reg[ddr_mode_pkg::DLL_DIS_BIT];
      o_reduced_drive <= extended_mode_reg[ddr_mode_pkg::DRV_BIT];
      // loop reset pulse only for the exact encoding
      o_loop_reset    <= mode_set && !i_bank_select_bit1 && !i_bank_select_bit0 &&
                         i_addr[12:7] == ddr_mode_pkg::HI_LOOP_RST;
      o_reserved_mode <= (hi_bits != ddr_mode_pkg::HI_NORMAL) &&
                         (hi_bits != ddr_mode_pkg::HI_LOOP_RST);
      o_reserved_code <= !bl_ok || !cl_ok;
    end
  end

  // column stream buffer toward the sink
  col_fifo #(
    .W     (COL_W + 1),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_data    ({wr_reg, col_now}),
    .i_valid   (fifo_push),
    .o_ready   (fifo_ready),
    .o_data    ({o_col_write, o_col}),
    .o_valid   (o_col_valid),
    .i_ready   (i_col_ready)
  );
endmodule

// ===== sim/ddr_mode_checker.sv
// Purpose: port checks of mode decode and read timing
// Assumes: one clock, async active-high reset
// Notes:   mode writes are spaced by the settle wait
`timescale 1ns/1ps
module ddr_mode_checker (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_ce,
  input wire logic        i_cs_n,
  input wire logic        i_ras_n,
  input wire logic        i_cas_n,
  input wire logic        i_we_n,
  input wire logic        i_bank_select_bit0,
  input wire logic        i_bank_select_bit1,
  input wire logic [12:0] i_addr,
  input wire logic        i_self_refresh_exit,
  input wire logic        o_cmd_ready,
  input wire logic        o_first_data,
  input wire logic        o_first_data_half,
  input wire logic [3:0]  o_burst_len,
  input wire logic        o_interleaved,
  input wire logic        o_loop_enable,
  input wire logic        o_loop_reset,
  input wire logic        o_reduced_drive
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // command decode
  wire logic [3:0] cmd  = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
  wire logic       ms   = i_ce && cmd == ddr_mode_pkg::CMD_MODE_SET && !i_bank_select_bit1;
  wire logic       ms_b = ms && !i_bank_select_bit0;
  wire logic       ms_e = ms && i_bank_select_bit0;
  wire logic       rd   = i_ce && cmd == ddr_mode_pkg::CMD_READ && o_cmd_ready;
  wire logic       rd_l = rd && o_burst_len != 4'h1;
  logic [2:0]      cl_q;
  // latency code of the last base write
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) cl_q <= 3'h0;
    else if (ms_b) cl_q <= i_addr[6:4];
  end
  // expected length for a code
  function automatic logic [3:0] bl(input logic [2:0] c);
    return c == 3'h1 ? 4'h2 : c == 3'h2 ? 4'h4 : c == 3'h3 ? 4'h8 : 4'h1;
  endfunction
  property p_len; ms_b |-> ##2 o_burst_len == bl($past(i_addr[2:0], 2)); endproperty
  a_len: assert property (p_len) else $error("length decode");
  property p_type; ms_b |-> ##2 o_interleaved == $past(i_addr[3], 2); endproperty
  a_type: assert property (p_type) else $error("burst type");
  property p_cl2; rd_l && cl_q[1:0] == 2'h2 |=> o_first_data; endproperty
  a_cl2: assert property (p_cl2) else $error("latency two");
  property p_cl3; rd_l && cl_q == 3'h3 |=> !o_first_data ##1 o_first_data; endproperty
  a_cl3: assert property (p_cl3) else $error("latency three");
  property p_half; ms_b && i_addr[6:4] == 3'h6 |-> ##2 o_first_data_half; endproperty
  a_half: assert property (p_half) else $error("half clock flag");
  property p_lrst; ms_b |=> o_loop_reset == ($past(i_addr[12:7]) == 6'h02); endproperty
  a_lrst: assert property (p_lrst) else $error("loop reset pulse");
  property p_ext;
    ms_e |-> ##2 {o_loop_enable, o_reduced_drive} == {!$past(i_addr[0], 2), $past(i_addr[1], 2)};
  endproperty
  a_ext: assert property (p_ext) else $error("extended write");
  property p_srx; i_ce && i_self_refresh_exit && !ms_e |-> ##2 o_loop_enable; endproperty
  a_srx: assert property (p_srx) else $error("loop not enabled");
  c_ilv: cover property (rd_l && o_interleaved);
  c_lrst: cover property (o_loop_reset);
  c_full: cover property (!o_cmd_ready);
endmodule

bind ddr_mode_and_burst_order ddr_mode_checker i_chk (.i_clk, .i_sys_rst, .i_ce, .i_cs_n,
  .i_ras_n, .i_cas_n, .i_we_n, .i_bank_select_bit0, .i_bank_select_bit1, .i_addr,
  .i_self_refresh_exit, .o_cmd_ready, .o_first_data, .o_first_data_half, .o_burst_len,
  .o_interleaved, .o_loop_enable, .o_loop_reset, .o_reduced_drive);

// ===== sim/ddr_ctrl_model.sv
// Purpose: controller model issuing mode, read and write commands
// Assumes: pins change just after a rising edge
// Notes:   idle address and bank lines are inverted, never held
`timescale 1ns/1ps
module ddr_ctrl_model #(
  parameter int MODE_SET_WAIT = 2
) (
  input  wire logic   i_clk,
  output logic [3:0]  o_cmd,
  output logic [1:0]  o_ba,
  output logic [12:0] o_addr
);
  logic [12:0] base_val = 13'h0000;
  // deselected at start
  initial begin
    o_cmd  = 4'hF;
    o_ba   = 2'h0;
    o_addr = 13'h1FFF;
  end
  // one command for one edge, then deselect
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    @(posedge i_clk);
    o_cmd  <= c;
    o_ba   <= b;
    o_addr <= a;
    @(posedge i_clk);
    o_cmd  <= 4'hF;
    o_ba   <= ~b;
    o_addr <= ~a;
    #1;
  endtask
  // mode write, settle wait, loop reset after enabling the loop
  task automatic mode_set(input logic [1:0] b, input logic [12:0] a);
    issue(ddr_mode_pkg::CMD_MODE_SET, b, a);
    repeat (MODE_SET_WAIT) @(posedge i_clk);
    if (b == 2'h0) base_val = a;
    if (b == 2'h1 && !a[0]) begin
      issue(ddr_mode_pkg::CMD_MODE_SET, 2'h0, {6'h02, base_val[6:0]});
      repeat (MODE_SET_WAIT) @(posedge i_clk);
      issue(ddr_mode_pkg::CMD_MODE_SET, 2'h0, {6'h00, base_val[6:0]});
      repeat (200) @(posedge i_clk);
    end
    #1;
  endtask
endmodule

// ===== sim/test_ddr_mode_and_burst_order.sv
// Purpose: self-checking bench for mode decode and burst order
// Assumes: controller model drives the command pins
// Notes:   column sink stalls while the buffer fills
`timescale 1ns/1ps
module test_ddr_mode_and_burst_order;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_ce = 1'b1;
  logic        i_self_refresh_exit = 1'b0;
  logic        i_col_ready = 1'b1;
  wire         i_cs_n, i_ras_n, i_cas_n, i_we_n, i_bank_select_bit0, i_bank_select_bit1;
  wire  [12:0] i_addr, o_col;
  wire  [3:0]  o_burst_len;
  wire         o_col_write, o_col_valid, o_cmd_ready, o_first_data, o_first_data_half;
  wire         o_interleaved, o_loop_enable, o_loop_reset, o_reduced_drive;
  wire         o_reserved_mode, o_reserved_code;
  int          bad_count = 0;
  int          checks = 0;
  // 125 MHz clock
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  ddr_ctrl_model i_ctl (.i_clk, .o_cmd({i_cs_n, i_ras_n, i_cas_n, i_we_n}),
    .o_ba({i_bank_select_bit1, i_bank_select_bit0}), .o_addr(i_addr));
  ddr_mode_and_burst_order i_dut (.i_clk, .i_sys_rst, .i_ce, .i_cs_n, .i_ras_n, .i_cas_n,
    .i_we_n, .i_bank_select_bit0, .i_bank_select_bit1, .i_addr, .i_self_refresh_exit,
    .i_col_ready, .o_col, .o_col_write, .o_col_valid, .o_cmd_ready, .o_first_data,
    .o_first_data_half, .o_burst_len, .o_interleaved, .o_loop_enable, .o_loop_reset,
    .o_reduced_drive, .o_reserved_mode, .o_reserved_code);
  // verdict and stop
  task automatic end_of_test;
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one edge, then settled outputs
  task automatic step;
    @(posedge i_clk);
    #1;
  endtask
  // one burst; every column from start, order and length
  task automatic burst(input logic [2:0] bl, input logic t, input logic [12:0] s);
    logic [12:0] m;
    int n;
    logic w;
    m = (13'h1 << bl) - 13'h1;
    w = t ^ bl[0];  // reads and writes in both orders
    i_ctl.mode_set(2'h0, {6'h00, ddr_mode_pkg::CL_CODE2, t, bl});
    chk(o_burst_len, 16'(m) + 16'h1);
    chk(o_interleaved, t);
    i_ctl.issue(w ? ddr_mode_pkg::CMD_WRITE : ddr_mode_pkg::CMD_READ, 2'h0, s);
    for (int i = 0; i <= m; i++) begin
      n = 0;
      while (o_col_valid !== 1'b1 && n < 20) begin
        step();
        n++;
      end
      if (o_col_valid !== 1'b1) begin
        bad_count++;
        end_of_test();
      end
      chk(o_col, s & ~m | (t ? s ^ 13'(i) : s + 13'(i)) & m);
      chk(o_col_write, w);
      step();
    end
    chk(o_col_valid, 1'b0);
  endtask
  // edges from the taken read to the first-data pulse
  task automatic latency(input logic [2:0] cl, input int d, input logic h);
    int n;
    i_ctl.mode_set(2'h0, {6'h00, cl, 1'b0, ddr_mode_pkg::BL_CODE2});
    chk({o_first_data_half, o_reserved_code}, {h, d == 5});
    i_ctl.issue(ddr_mode_pkg::CMD_READ, 2'h0, 13'h0010);
    n = 1;
    while (o_first_data !== 1'b1 && n < 5) begin
      step();
      n++;
    end
    chk(16'(n), 16'(d));
    repeat (6) step();
  endtask
  // reserved high field, extended register, self refresh exit
  task automatic modes;
    i_ctl.issue(ddr_mode_pkg::CMD_MODE_SET, 2'h0, 13'h0422);
    repeat (2) step();
    chk(o_reserved_mode, 1'b1);
    i_ctl.mode_set(2'h1, 13'h0003);
    chk({o_loop_enable, o_reduced_drive}, 2'h1);
    @(posedge i_clk) i_self_refresh_exit <= 1'b1;
    @(posedge i_clk) i_self_refresh_exit <= 1'b0;
    repeat (2) step();
    chk(o_loop_enable, 1'b1);
    i_ctl.mode_set(2'h1, 13'h0000);
    chk({o_loop_enable, o_reduced_drive, o_reserved_mode}, 3'h4);
  endtask
  // stall the sink until the buffer refuses, then drain it
  task automatic fill;
    int n;
    i_ctl.mode_set(2'h0, {6'h00, ddr_mode_pkg::CL_CODE2, 1'b0, ddr_mode_pkg::BL_CODE8});
    @(posedge i_clk) i_col_ready <= 1'b0;
    #1;
    n = 0;
    while (o_cmd_ready === 1'b1 && n < 8) begin
      i_ctl.issue(ddr_mode_pkg::CMD_READ, 2'h0, 13'h0040);
      repeat (9) step();
      n++;
    end
    chk(16'(n), 16'h4);
    @(posedge i_clk) i_col_ready <= 1'b1;
    #1;
    n = 0;
    repeat (40) begin
      n += o_col_valid;
      step();
    end
    chk({n == 32, o_cmd_ready}, 2'h3);
  endtask
  // clock enable low: a base write is not stored
  task automatic freeze;
    @(posedge i_clk) i_ce <= 1'b0;
    i_ctl.issue(ddr_mode_pkg::CMD_MODE_SET, 2'h0, 13'h0021);
    repeat (2) step();
    chk(o_burst_len, 16'h8);
    @(posedge i_clk) i_ce <= 1'b1;
    step();
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    for (int b = 1; b < 4; b++) begin
      for (int t = 0; t < 2; t++) begin
        burst(3'(b), 1'(t), {10'h2A5, 3'(2 * b + 1)});
      end
    end
    latency(3'h1, 5, 1'b0);
    latency(ddr_mode_pkg::CL_CODE2, 1, 1'b0);
    latency(ddr_mode_pkg::CL_CODE3, 2, 1'b0);
    latency(ddr_mode_pkg::CL_CODE25, 1, 1'b1);
    modes();
    fill();
    freeze();
    end_of_test();
  end
endmodule
